// *** design/icfl_pkg.sv ***
// Purpose: constants and types of the interrupt enable and flag logic
// Assumes: byte addresses on a 16-bit Avalon-MM address
// Notes: every offset and field position, and the select, flag and polarity reset values, live here
package icfl_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] ICFL_OFS_POL = 16'h3000;
  localparam logic [15:0] ICFL_OFS_CLR = 16'h3004;
  localparam logic [15:0] ICFL_OFS_SEL0 = 16'h3008;
  localparam logic [15:0] ICFL_OFS_SEL1 = 16'h300C;
  localparam logic [15:0] ICFL_OFS_FLAG0 = 16'h3010;
  localparam logic [15:0] ICFL_OFS_FLAG1 = 16'h3014;
  localparam logic [15:0] ICFL_OFS_STAT = 16'h3018;
  localparam logic [15:0] ICFL_OFS_MASK = 16'h301C;
  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [31:0] ICFL_SEL_RESET = 32'h00002000;
  localparam logic [31:0] ICFL_FLAG_RESET = 32'h00000000;
  localparam logic [31:0] ICFL_FLAG_VALID = 32'hAF83BFFF;
  localparam int ICFL_BIT_COLLIDE = 31;
  localparam int ICFL_BIT_OUTLIER = 29;
  localparam int ICFL_BIT_FIFO_HI = 27;
  localparam int ICFL_BIT_FIFO_LO = 23;
  localparam int ICFL_BIT_SEQ_HI = 17;
  localparam int ICFL_BIT_SEQ_LO = 15;
  localparam int ICFL_BIT_BOOT = 13;
  localparam int ICFL_BIT_CUST_HI = 12;
  localparam int ICFL_BIT_CUST_LO = 9;
  localparam int ICFL_BIT_POL = 0;
  localparam int ICFL_STAT_W = 3;
  localparam int ICFL_STAT_COLLIDE = 0;
  localparam int ICFL_STAT_LINE0 = 1;
  localparam int ICFL_STAT_LINE1 = 2;
  localparam logic ICFL_POL_RESET = 1'b0;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ICFL_BUS_IDLE = 2'b00,
    ICFL_BUS_ACK = 2'b01
  } icfl_bus_t;
  typedef enum logic [1:0] {
    ICFL_SEQ_IDLE = 2'b00,
    ICFL_SEQ_A = 2'b01,
    ICFL_SEQ_B = 2'b10
  } icfl_seq_t;
endpackage : icfl_pkg

// *** design/icfl_flag_bank.sv ***
// Purpose: one interrupt line: select register and sticky flag register
// Assumes: events and clears are one-cycle pulses on clk_i
// Notes: a set in the same cycle as its clear wins
`timescale 1ns/10ps
module icfl_flag_bank
  import icfl_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sel_we_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] bemask_i,
  input wire logic [31:0] clr_i,
  input wire logic [31:0] evt_i,
  output logic [31:0] sel_o,
  output logic [31:0] flags_o
);
  logic [31:0] sel_r;
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // enable bits, byte-lane masked writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_r <= ICFL_SEL_RESET;
    end else if (sel_we_i) begin
      sel_r <= (sel_r & ~bemask_i) | (wdata_i & bemask_i); // [R1] [R2] [R3]
    end
  end

  // sticky flags: enabled event sets, write-one clears, set wins
  assign flags_nxt = ((flags_r & ~clr_i) | (evt_i & sel_r)) & ICFL_FLAG_VALID; // [R9] [R11] [R8]
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_r <= ICFL_FLAG_RESET; // [R4]
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign sel_o = sel_r;
  assign flags_o = flags_r;

  flag_set_a: assert property (|(evt_i & sel_r & ICFL_FLAG_VALID) |=> // [R11]
    ((flags_r & $past(evt_i & sel_r & ICFL_FLAG_VALID)) == $past(evt_i & sel_r & ICFL_FLAG_VALID)))
    else $error("enabled event did not set its flag");
  flag_hold_a: assert property (clr_i == 32'h00000000 |=> // [R11]
    ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag dropped without a clear");
  flag_gate_a: assert property (evt_i != 32'h00000000 |=> // [R11]
    ((flags_r & ~$past(flags_r) & ~$past(sel_r)) == 32'h00000000))
    else $error("disabled source raised a flag");
endmodule : icfl_flag_bank

// *** design/icfl_seq_guard.sv ***
// Purpose: watches sequence start requests and flags a collision
// Assumes: requests and done are one-cycle pulses on clk_i
// Notes: a second request during a running sequence is dropped
`timescale 1ns/10ps
module icfl_seq_guard
  import icfl_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic a_req_i,
  input wire logic b_req_i,
  input wire logic done_i,
  output logic a_start_o,
  output logic b_start_o,
  output logic collide_o
);
  icfl_seq_t st_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // run state and start / collision pulses
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= ICFL_SEQ_IDLE;
      a_start_o <= 1'b0;
      b_start_o <= 1'b0;
      collide_o <= 1'b0;
    end else begin
      a_start_o <= 1'b0;
      b_start_o <= 1'b0;
      collide_o <= 1'b0;
      case (st_r)
        ICFL_SEQ_IDLE: begin
          if (a_req_i) begin
            st_r <= ICFL_SEQ_A;
            a_start_o <= 1'b1;
          end else if (b_req_i) begin
            st_r <= ICFL_SEQ_B;
            b_start_o <= 1'b1;
          end
        end
        ICFL_SEQ_A: begin
          collide_o <= b_req_i; // second request dropped, not queued [R5]
          if (done_i) begin
            st_r <= ICFL_SEQ_IDLE;
          end
        end
        ICFL_SEQ_B: begin
          if (done_i) begin
            st_r <= ICFL_SEQ_IDLE;
          end
        end
        default: st_r <= ICFL_SEQ_IDLE;
      endcase
    end
  end

  seq_collide_a: assert property (st_r == ICFL_SEQ_A && b_req_i |=> // [R5]
    collide_o && !b_start_o ##1 !b_start_o)
    else $error("collision not flagged or request queued");
  seq_collide_c: cover property (st_r == ICFL_SEQ_A && b_req_i);
endmodule : icfl_seq_guard

// *** design/icfl_top.sv ***
// Purpose: interrupt enable and flag logic with an Avalon-MM register port
// Assumes: one clock, synchronous active-high reset, sources on clk_i
// Notes: two lines share one clear register and one polarity bit
//
// Function
// R1 - select bits 12..9 enable custom interrupts 3..0, reset zero
// R2 - select bits 8..4 enable variance, mean, delta, max, min fail events
// R3 - select bits 3..0 enable temperature, sinc2, DFT, converter result events
// R4 - two read-only 32-bit flag registers, zero after reset, one means asserted
// R5 - sequence B request during running sequence A sets bit 31, is ignored
// R6 - bit 29 outlier; bits 27..23 FIFO underflow, overflow, threshold, empty, full
// R7 - bits 17, 16, 15 timeout error, timeout finished, end of sequence
// R8 - bit 13 boot load done; bits 30, 28, 22..18, 14 read zero
// R9 - writing one to a clear bit clears that flag; zero does nothing
// R10 - polarity bit zero gives falling-edge output, one gives rising-edge
// R11 - flag n sets only on event enabled in select n, sticky until cleared
// R12 - each line output signals while any bit of its flag register is set
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
module icfl_top
  import icfl_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [31:0] src_evt_i,
  input wire logic seq_a_req_i,
  input wire logic seq_b_req_i,
  input wire logic seq_done_i,
  output logic seq_a_start_o,
  output logic seq_b_start_o,
  output logic irq_line0_o,
  output logic irq_line1_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte enables to a bit mask
  function automatic logic [31:0] icfl_bemask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : icfl_bemask

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  icfl_bus_t bus_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic wr_go;
  logic [31:0] bemask;
  logic [31:0] wmask_data;
  logic pol_r;
  logic [ICFL_STAT_W-1:0] stat_r;
  logic [ICFL_STAT_W-1:0] stat_nxt;
  logic [ICFL_STAT_W-1:0] mask_r;
  logic [ICFL_STAT_W-1:0] stat_evt;
  logic [ICFL_STAT_W-1:0] stat_w1c;
  logic [31:0] clr_vec;
  logic [31:0] evt_vec;
  logic [31:0] sel0;
  logic [31:0] sel1;
  logic [31:0] flags0;
  logic [31:0] flags1;
  logic any0;
  logic any1;
  logic any0_d_r;
  logic any1_d_r;
  logic collide;
  logic line0_r;
  logic line1_r;
  logic irq_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ---------------------------------------------------------------
  // request seen in idle -> ack cycle with waitrequest low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_r <= ICFL_BUS_IDLE;
      wait_r <= 1'b1;
    end else begin
      case (bus_r)
        ICFL_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_r <= ICFL_BUS_ACK;
            wait_r <= 1'b0;
          end
        end
        ICFL_BUS_ACK: begin
          bus_r <= ICFL_BUS_IDLE;
          wait_r <= 1'b1;
        end
        default: begin
          bus_r <= ICFL_BUS_IDLE;
          wait_r <= 1'b1;
        end
      endcase
    end
  end

  // write takes effect at the edge that sees waitrequest low
  assign wr_go = avs_write_i && (bus_r == ICFL_BUS_ACK);
  assign bemask = icfl_bemask(avs_byteenable_i);
  assign wmask_data = avs_writedata_i & bemask;

  // read data captured on entry to the ack cycle; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h00000000;
    end else if (bus_r == ICFL_BUS_IDLE && avs_read_i) begin
      case (avs_address_i)
        ICFL_OFS_POL: rdata_r <= {31'h00000000, pol_r};
        ICFL_OFS_SEL0: rdata_r <= sel0;
        ICFL_OFS_SEL1: rdata_r <= sel1;
        ICFL_OFS_FLAG0: rdata_r <= flags0; // [R4]
        ICFL_OFS_FLAG1: rdata_r <= flags1; // [R4]
        ICFL_OFS_STAT: rdata_r <= {29'h00000000, stat_r};
        ICFL_OFS_MASK: rdata_r <= {29'h00000000, mask_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // output polarity bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pol_r <= ICFL_POL_RESET;
    end else if (wr_go && avs_address_i == ICFL_OFS_POL && avs_byteenable_i[0]) begin
      pol_r <= avs_writedata_i[ICFL_BIT_POL]; // [R10]
    end
  end

  // block status mask
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_r <= '0;
    end else if (wr_go && avs_address_i == ICFL_OFS_MASK && avs_byteenable_i[0]) begin
      mask_r <= avs_writedata_i[ICFL_STAT_W-1:0];
    end
  end

  // write-one clear pulses, shared by both lines
  assign clr_vec = (wr_go && avs_address_i == ICFL_OFS_CLR) ? wmask_data : 32'h00000000; // [R9]

  // ---------------------------------------------------------------
  // event sources and flag banks
  // ---------------------------------------------------------------
  icfl_seq_guard u_guard (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .a_req_i(seq_a_req_i),
    .b_req_i(seq_b_req_i),
    .done_i(seq_done_i),
    .a_start_o(seq_a_start_o),
    .b_start_o(seq_b_start_o),
    .collide_o(collide)
  );

  // collision replaces the external source at bit 31; reserved bits masked in banks
  always_comb begin
    evt_vec = src_evt_i; // [R6] [R7] [R8]
    evt_vec[ICFL_BIT_COLLIDE] = collide; // [R5]
  end

  icfl_flag_bank u_bank0 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sel_we_i(wr_go && avs_address_i == ICFL_OFS_SEL0),
    .wdata_i(avs_writedata_i),
    .bemask_i(bemask),
    .clr_i(clr_vec),
    .evt_i(evt_vec),
    .sel_o(sel0),
    .flags_o(flags0)
  );

  icfl_flag_bank u_bank1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sel_we_i(wr_go && avs_address_i == ICFL_OFS_SEL1),
    .wdata_i(avs_writedata_i),
    .bemask_i(bemask),
    .clr_i(clr_vec),
    .evt_i(evt_vec),
    .sel_o(sel1),
    .flags_o(flags1)
  );

  assign any0 = |flags0;
  assign any1 = |flags1;

  // ---------------------------------------------------------------
  // line outputs with selectable polarity
  // ---------------------------------------------------------------
  // idle high and falls when polarity is zero, idle low and rises when one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line0_r <= 1'b1;
      line1_r <= 1'b1;
    end else begin
      line0_r <= pol_r ? any0 : ~any0; // [R10] [R12]
      line1_r <= pol_r ? any1 : ~any1; // [R10] [R12]
    end
  end

  // ---------------------------------------------------------------
  // block status, mask and interrupt
  // ---------------------------------------------------------------
  // delayed any-flag levels for rise detection
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      any0_d_r <= 1'b0;
      any1_d_r <= 1'b0;
    end else begin
      any0_d_r <= any0;
      any1_d_r <= any1;
    end
  end

  assign stat_evt[ICFL_STAT_COLLIDE] = collide;
  assign stat_evt[ICFL_STAT_LINE0] = any0 & ~any0_d_r;
  assign stat_evt[ICFL_STAT_LINE1] = any1 & ~any1_d_r;
  assign stat_w1c = (wr_go && avs_address_i == ICFL_OFS_STAT) ? wmask_data[ICFL_STAT_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~stat_w1c) | stat_evt; // set wins over clear

  // sticky status and masked level interrupt
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign irq_line0_o = line0_r;
  assign irq_line1_o = line1_r;
  assign irq_o = irq_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  bus_answer_a: assert property (bus_r == ICFL_BUS_IDLE && (avs_read_i || avs_write_i) |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not exactly one cycle after request");
  flag_reset_a: assert property ($past(reset_i) |-> flags0 == 32'h00000000 && // [R4]
    flags1 == 32'h00000000)
    else $error("flags not zero after reset");
  reserved_zero_a: assert property (((flags0 | flags1) & ~ICFL_FLAG_VALID) == 32'h00000000) // [R8]
    else $error("reserved flag bit set");
  flag_clear_a: assert property (wr_go && avs_address_i == ICFL_OFS_CLR && // [R9]
    avs_byteenable_i == 4'hF && (avs_writedata_i & evt_vec) == 32'h00000000 |=>
    (flags0 & $past(avs_writedata_i)) == 32'h00000000)
    else $error("write-one clear left a flag set");
  sel_write_a: assert property (wr_go && avs_address_i == ICFL_OFS_SEL1 && // [R1] [R2] [R3]
    avs_byteenable_i == 4'hF |=> sel1 == $past(avs_writedata_i))
    else $error("select register write lost");
  line_pol_a: assert property (##1 irq_line0_o == ($past(pol_r) ? $past(any0) : !$past(any0))) // [R10] [R12]
    else $error("line output wrong for polarity");
  flag_read_a: assert property (bus_r == ICFL_BUS_IDLE && avs_read_i && // [R4]
    avs_address_i == ICFL_OFS_FLAG1 |=> avs_readdata_o == $past(flags1))
    else $error("flag read returned wrong value");
  irq_level_a: assert property ((stat_r & mask_r) != '0 && stat_w1c == '0 |=> irq_o)
    else $error("masked status set but interrupt low");
  collide_flag_a: assert property (collide && sel0[ICFL_BIT_COLLIDE] |=> // [R5]
    flags0[ICFL_BIT_COLLIDE])
    else $error("collision did not raise flag");

  // slave stays waiting while no request stands
  bus_idle_a: assert property (bus_r == ICFL_BUS_IDLE &&
    !avs_read_i && !avs_write_i |=>
    avs_waitrequest_o)
    else $error("waitrequest low with no request");

  // the other register of each pair, and the read-only flags
  sel0_write_a: assert property (wr_go && // [R1] [R2] [R3]
    avs_address_i == ICFL_OFS_SEL0 && avs_byteenable_i == 4'hF |=>
    sel0 == $past(avs_writedata_i))
    else $error("select 0 write lost");
  flag0_read_a: assert property (bus_r == ICFL_BUS_IDLE && // [R4]
    avs_read_i && avs_address_i == ICFL_OFS_FLAG0 |=>
    avs_readdata_o == $past(flags0))
    else $error("flag 0 read wrong");
  flag_ro_a: assert property (wr_go && // [R4]
    avs_address_i == ICFL_OFS_FLAG0 && evt_vec == 32'h00000000 |=>
    flags0 == $past(flags0))
    else $error("read-only flags written");
  flag1_clear_a: assert property (wr_go && // [R9]
    avs_address_i == ICFL_OFS_CLR && avs_byteenable_i == 4'hF &&
    (avs_writedata_i & evt_vec) == 32'h00000000 |=>
    (flags1 & $past(avs_writedata_i)) == 32'h00000000)
    else $error("line 1 flag not cleared");

  // collision flag comes from the guard alone
  collide_only_a: assert property (!collide |=> // [R5]
    !$rose(flags0[ICFL_BIT_COLLIDE]) &&
    !$rose(flags1[ICFL_BIT_COLLIDE]))
    else $error("collision flag without collision");

  // polarity bit and second line
  pol_write_a: assert property (wr_go && // [R10]
    avs_address_i == ICFL_OFS_POL && avs_byteenable_i[0] |=>
    pol_r == $past(avs_writedata_i[ICFL_BIT_POL]))
    else $error("polarity write lost");
  line1_pol_a: assert property (##1 // [R10] [R12]
    irq_line1_o == ($past(pol_r) ? $past(any1) : !$past(any1)))
    else $error("line 1 wrong for polarity");

  // status rise, write-one clear and quiet interrupt
  stat_line_a: assert property (any1 && !any1_d_r |=>
    stat_r[ICFL_STAT_LINE1])
    else $error("line 1 rise not in status");
  stat_clear_a: assert property (stat_w1c != '0 &&
    stat_evt == '0 |=> (stat_r & $past(stat_w1c)) == '0)
    else $error("status not cleared");
  irq_low_a: assert property ((stat_nxt & mask_r) == '0 |=>
    !irq_o)
    else $error("interrupt high with nothing masked in");

  read_flag_c: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == ICFL_OFS_FLAG0);
  clear_flag_c: cover property (wr_go && avs_address_i == ICFL_OFS_CLR && any0);
  line_rise_c: cover property (pol_r && $rose(irq_line1_o));
  irq_c: cover property ($rose(irq_o));
endmodule : icfl_top

// *** verification/icfl_host_model.sv ***
// Purpose: host controller model driving the Avalon-MM register port
// Assumes: one access at a time, slave answers by waitrequest low
// Notes: a hang is reported to the caller instead of waiting forever
`timescale 1ns/10ps
module icfl_host_model (
  input wire logic clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [15:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  // idle bus at time zero
  initial begin
    avs_address_o = 16'h0000;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h00000000;
    avs_byteenable_o = 4'h0;
  end
  // one access: raise after an edge, hold until waitrequest low, then release
  task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                        input logic [3:0] be, output logic [31:0] rdata, output bit hung);
    int n;
    @(posedge clk_i);
    avs_address_o <= addr;
    avs_writedata_o <= wdata;
    avs_byteenable_o <= be;
    avs_read_o <= ~wr;
    avs_write_o <= wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_i !== 1'b0 && n < 64);
    rdata = avs_readdata_i;
    hung = (n >= 64);
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // released address and data lines carry the inverted values; byte enables keep theirs
    avs_address_o <= ~addr;
    avs_writedata_o <= ~wdata;
  endtask : access
endmodule : icfl_host_model

// *** verification/icfl_top_test.sv ***
// Purpose: self-checking bench of the interrupt enable and flag logic
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes: table rows cover enables and flags, hand tests the awkward cases
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module icfl_top_test
  import icfl_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [15:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, src_evt_i;
  logic [3:0] avs_byteenable_i;
  logic seq_a_req_i, seq_b_req_i, seq_done_i, seq_a_start_o, seq_b_start_o;
  logic irq_line0_o, irq_line1_o, irq_o;
  int num_errors = 0;
  int samples_checked = 0;
  int b_starts = 0;
  typedef struct {logic [31:0] evt, sel0, sel1, exp0, exp1;} icfl_row_t;
  icfl_row_t rows [6] = '{
    '{32'h00001000, 32'hFFFFFFFF, 32'h00000000, 32'h00001000, 32'h00000000},
    '{32'h000001F0, 32'h00000000, 32'h000001F0, 32'h00000000, 32'h000001F0},
    '{32'h0000000F, 32'h00000005, 32'h0000000A, 32'h00000005, 32'h0000000A},
    '{32'h2F83A000, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h2F83A000, 32'h2F83A000},
    '{32'h507C4000, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000, 32'h00000000},
    '{32'h00001E00, 32'h00000600, 32'h00001800, 32'h00000600, 32'h00001800}
  };
  icfl_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .src_evt_i(src_evt_i), .seq_a_req_i(seq_a_req_i),
    .seq_b_req_i(seq_b_req_i), .seq_done_i(seq_done_i), .seq_a_start_o(seq_a_start_o),
    .seq_b_start_o(seq_b_start_o), .irq_line0_o(irq_line0_o), .irq_line1_o(irq_line1_o), .irq_o(irq_o));
  icfl_host_model u_host (.clk_i(clk_i), .avs_waitrequest_i(avs_waitrequest_o),
    .avs_readdata_i(avs_readdata_o), .avs_address_o(avs_address_i), .avs_read_o(avs_read_i),
    .avs_write_o(avs_write_i), .avs_writedata_o(avs_writedata_i), .avs_byteenable_o(avs_byteenable_i));
  // ---------------------------------------------------------------
  // clock, monitors and tasks
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // counts started second sequences
  always @(posedge clk_i) begin
    if (seq_b_start_o === 1'b1) b_starts++;
  end
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] x;
    bit h;
    u_host.access(1'b1, a, d, be, x, h);
    if (h) begin
      num_errors++;
      summarize();
    end
  endtask : wr
  task automatic chk_rd(input string nm, input logic [15:0] a, input logic [31:0] ex);
    logic [31:0] x;
    bit h;
    u_host.access(1'b0, a, 32'h00000000, 4'hF, x, h);
    if (h) begin
      num_errors++;
      summarize();
    end
    `CHK(nm, ex, x);
  endtask : chk_rd
  task automatic pulse_evt(input logic [31:0] e);
    @(posedge clk_i);
    src_evt_i <= e;
    @(posedge clk_i);
    src_evt_i <= 32'h00000000;
  endtask : pulse_evt
  // one-cycle pulse of {done, b request, a request}
  task automatic seq_pulse(input logic [2:0] v);
    @(posedge clk_i);
    {seq_done_i, seq_b_req_i, seq_a_req_i} <= v;
    @(posedge clk_i);
    {seq_done_i, seq_b_req_i, seq_a_req_i} <= 3'b000;
  endtask : seq_pulse
  task automatic wait_start(input bit b);
    bit seen;
    seen = 1'b0;
    for (int n = 0; n < 20 && !seen; n++) begin
      #1;
      seen = b ? (seq_b_start_o === 1'b1) : (seq_a_start_o === 1'b1);
      if (!seen) @(posedge clk_i);
    end
    if (!seen) begin
      num_errors++;
      summarize();
    end
  endtask : wait_start
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    src_evt_i = 32'h00000000;
    {seq_done_i, seq_b_req_i, seq_a_req_i} = 3'b000;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_rd("sel0 reset", ICFL_OFS_SEL0, ICFL_SEL_RESET);
    chk_rd("sel1 reset", ICFL_OFS_SEL1, ICFL_SEL_RESET);
    chk_rd("flag0 reset", ICFL_OFS_FLAG0, ICFL_FLAG_RESET);
    chk_rd("flag1 reset", ICFL_OFS_FLAG1, ICFL_FLAG_RESET);
    `CHK("line0 idle", 1'b1, irq_line0_o);
    // table: enable, fire, read both flag registers, clear
    foreach (rows[i]) begin
      wr(ICFL_OFS_SEL0, rows[i].sel0, 4'hF);
      wr(ICFL_OFS_SEL1, rows[i].sel1, 4'hF);
      pulse_evt(rows[i].evt);
      chk_rd("flag0", ICFL_OFS_FLAG0, rows[i].exp0);
      chk_rd("flag1", ICFL_OFS_FLAG1, rows[i].exp1);
      `CHK("line0", rows[i].exp0 == 32'h00000000, irq_line0_o);
      `CHK("line1", rows[i].exp1 == 32'h00000000, irq_line1_o);
      wr(ICFL_OFS_CLR, 32'hFFFFFFFF, 4'hF);
      chk_rd("flag1 cleared", ICFL_OFS_FLAG1, 32'h00000000);
    end
    // read-only flags, unmapped place, single byte lane
    wr(ICFL_OFS_FLAG0, 32'hFFFFFFFF, 4'hF);
    chk_rd("flag0 written", ICFL_OFS_FLAG0, 32'h00000000);
    wr(16'h3020, 32'hFFFFFFFF, 4'hF);
    chk_rd("unmapped", 16'h3020, 32'h00000000);
    wr(ICFL_OFS_SEL1, 32'hFFFFFFFF, 4'h2);
    chk_rd("sel1 lane1", ICFL_OFS_SEL1, 32'h0000FF00);
    // clear by zero is harmless, clear by one is per bit
    wr(ICFL_OFS_SEL0, 32'hFFFFFFFF, 4'hF);
    pulse_evt(32'h00030000);
    wr(ICFL_OFS_CLR, 32'h00000000, 4'hF);
    chk_rd("flag0 kept", ICFL_OFS_FLAG0, 32'h00030000);
    wr(ICFL_OFS_CLR, 32'h00010000, 4'hF);
    chk_rd("flag0 partial", ICFL_OFS_FLAG0, 32'h00020000);
    // rising polarity: line high while set, low when clear
    wr(ICFL_OFS_POL, 32'h00000001, 4'h1);
    chk_rd("pol", ICFL_OFS_POL, 32'h00000001);
    `CHK("line0 pol1 set", 1'b1, irq_line0_o);
    wr(ICFL_OFS_CLR, 32'hFFFFFFFF, 4'hF);
    chk_rd("flag0 clr", ICFL_OFS_FLAG0, 32'h00000000);
    `CHK("line0 pol1 idle", 1'b0, irq_line0_o);
    `CHK("line1 pol1 idle", 1'b0, irq_line1_o);
    wr(ICFL_OFS_POL, 32'h00000000, 4'h1);
    // second request while the first sequence runs
    wr(ICFL_OFS_SEL0, 32'h80000000, 4'hF);
    chk_rd("status lines", ICFL_OFS_STAT, 32'h00000006);
    wr(ICFL_OFS_STAT, 32'h00000007, 4'h1);
    seq_pulse(3'b001);
    wait_start(1'b0);
    seq_pulse(3'b010);
    repeat (3) @(posedge clk_i);
    `CHK("b starts in A", 0, b_starts);
    chk_rd("flag0 collide", ICFL_OFS_FLAG0, 32'h80000000);
    chk_rd("status", ICFL_OFS_STAT, 32'h00000003);
    `CHK("irq masked", 1'b0, irq_o);
    seq_pulse(3'b100);
    seq_pulse(3'b010);
    wait_start(1'b1);
    repeat (2) @(posedge clk_i);
    `CHK("b starts idle", 1, b_starts);
    // interrupt output: unmask, then clear the status bit
    wr(ICFL_OFS_MASK, 32'h00000001, 4'h1);
    chk_rd("mask", ICFL_OFS_MASK, 32'h00000001);
    `CHK("irq raised", 1'b1, irq_o);
    wr(ICFL_OFS_STAT, 32'h00000001, 4'h1);
    chk_rd("status clr", ICFL_OFS_STAT, 32'h00000002);
    `CHK("irq cleared", 1'b0, irq_o);
    // second reset in mid-run
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_rd("flag0 rereset", ICFL_OFS_FLAG0, ICFL_FLAG_RESET);
    chk_rd("sel0 rereset", ICFL_OFS_SEL0, ICFL_SEL_RESET);
    `CHK("line0 rereset", 1'b1, irq_line0_o);
    summarize();
  end
endmodule : icfl_top_test
